// File: hw/eeprom_params.svh
// How it works
// (R01) Data moves only while clock low
// (R02) Falling data, clock high: start, expect address
// (R03) Rising data, clock high: stop, then standby
// (R04) Standby at power-up and after stop
// (R05) Eight-bit words, acknowledge low on ninth
// (R06) Sample on rising edge, launch on falling
// (R07) Data line is open-drain, pull or release
// (R08) Address word: 1010, selects, direction bit
// (R09) Compare three select bits with select pins
// (R10) Floating select pin reads as zero
// (R11) Direction high reads, low writes
// (R12) Match acknowledges, mismatch returns to standby
// (R13) Write protect high blocks all writes
// (R14) 256 pages of 64, 14-bit address
// (R15) Master recovers with nine clocks, then start
// (R16) Write sends two acknowledged address bytes
// (R17) Self-timed write after stop, no acknowledge
// (R18) Mid-word start or stop abandons the word
// (R19) Without acknowledge, stay released until start
`ifndef EEPROM_PARAMS_SVH
`define EEPROM_PARAMS_SVH

`define DEV_TYPE 4'ha
`define WORD_BITS 8
`define BIT_CNT_W 4
`define WORD_DONE_CNT 4'h8
`define ACK_IN_CNT 4'h9
`define ADDR_W 14
`define PAGE_OFS_W 6
`define ADDR_HI_W 6
`define IDX_ADDR_HI 2'h0
`define IDX_ADDR_LO 2'h1
`define IDX_DATA 2'h2
`define TWR_MS 3
`define CORE_MHZ 100

`endif

// File: hw/eeprom_pkg.sv
`include "eeprom_params.svh"

package eeprom_pkg;

   typedef enum logic [7:0] {
      ST_STANDBY = 8'h01,
      ST_DEV_ADDR = 8'h02,
      ST_ACK_OUT = 8'h04,
      ST_RX_BYTE = 8'h08,
      ST_TX_BYTE = 8'h10,
      ST_ACK_IN = 8'h20,
      ST_IGNORE = 8'h40,
      ST_WRITE_CYCLE = 8'h80
   } bus_state_e;

   typedef struct packed {
      logic scl;
      logic sda;
   } line_s;

   typedef struct packed {
      logic wr;
      logic [`ADDR_W-1:0] addr;
      logic [`WORD_BITS-1:0] wdata;
   } mem_req_s;

endpackage : eeprom_pkg

// File: hw/scl_bit_sampler.sv
`timescale 1ns/1ns

module scl_bit_sampler (
   // Link clock
   input wire logic scl,
   // Reset from the core side
   input wire logic srst,
   // Serial data pin
   input wire logic sda,
   // Sampled bit with its event toggle
   output logic bit_value,
   output logic bit_toggle
);

   // Bus clock may stand still in reset, so reset acts without it
   // Limitation: release reset only while the bus clock is steady
   always_ff @(posedge scl or posedge srst) begin
      if (srst) begin
         bit_value <= 1'b0;
         bit_toggle <= 1'b0;
      end else begin
         bit_value <= sda; // R06
         bit_toggle <= ~bit_toggle;
      end
   end

endmodule : scl_bit_sampler

// File: hw/serial_eeprom_bus_front_end.sv
`timescale 1ns/1ns
`include "eeprom_params.svh"

module serial_eeprom_bus_front_end
   import eeprom_pkg::*;
#(
   parameter int TWR_CYCLES = `TWR_MS * 1000 * `CORE_MHZ
) (
   // Core clock and reset
   input wire logic CORE_CLK,
   input wire logic SRST,
   // Two-wire bus
   input wire logic SCL,
   input wire logic SDA_IN,
   output logic SDA_OUT,
   output logic SDA_OE_N,
   // Straps and protection
   input wire logic SELECT_PIN_HIGH,
   input wire logic SELECT_PIN_MID,
   input wire logic SELECT_PIN_LOW,
   input wire logic WRITE_PROTECT,
   // Array port
   output mem_req_s MEM_REQ,
   input wire logic [`WORD_BITS-1:0] MEM_RDATA,
   // Status
   output logic STANDBY,
   output logic WRITE_BUSY,
   output logic READ_MODE
);

   localparam int TWR_W = $clog2(TWR_CYCLES + 1);

   ////////////////////////////////////////////////////////////////////////////////
   // Crossings into the core domain

   line_s line_meta;
   line_s line_sync;
   line_s line_prev;
   logic [3:0] strap_meta;
   logic [3:0] strap_sync;
   logic tog_meta;
   logic tog_sync;
   logic tog_prev;
   logic link_bit;
   logic link_toggle;

   scl_bit_sampler u_sampler (
      .scl(SCL),
      .srst(SRST),
      .sda(SDA_IN),
      .bit_value(link_bit),
      .bit_toggle(link_toggle)
   );

   // Pad bias pulls floating select pins low, so plain sampling suffices
   always_ff @(posedge CORE_CLK) begin
      line_meta <= '{scl: SCL, sda: SDA_IN};
      line_sync <= line_meta;
      line_prev <= line_sync;
      strap_meta <= {WRITE_PROTECT, SELECT_PIN_HIGH, SELECT_PIN_MID, SELECT_PIN_LOW}; // R10
      strap_sync <= strap_meta;
      tog_meta <= link_toggle;
      tog_sync <= tog_meta;
   end

   // Bit is stable from its toggle until the next rising clock edge
   always_ff @(posedge CORE_CLK) begin
      tog_prev <= tog_sync;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Bus events

   wire rise_evt = tog_sync ^ tog_prev; // R06
   wire fall_evt = line_prev.scl & ~line_sync.scl;
   wire clock_high = line_sync.scl & line_prev.scl;
   wire start_evt = clock_high & line_prev.sda & ~line_sync.sda; // R01 R02
   wire stop_evt = clock_high & ~line_prev.sda & line_sync.sda; // R01 R03
   wire write_block = strap_sync[3];
   wire [2:0] select_pins = strap_sync[2:0];

   ////////////////////////////////////////////////////////////////////////////////
   // State

   bus_state_e state;
   bus_state_e next_state;
   logic [`BIT_CNT_W-1:0] bit_cnt;
   logic [`BIT_CNT_W-1:0] next_bit_cnt;
   logic [`WORD_BITS-1:0] shreg;
   logic [`WORD_BITS-1:0] next_shreg;
   logic [1:0] byte_idx;
   logic [1:0] next_byte_idx;
   logic rw;
   logic next_rw;
   logic [`ADDR_W-1:0] addr;
   logic [`ADDR_W-1:0] next_addr;
   logic pending;
   logic next_pending;
   logic [TWR_W-1:0] wait_cnt;
   logic [TWR_W-1:0] next_wait_cnt;
   logic oe_n;
   logic next_oe_n;
   logic next_wr;
   logic [`WORD_BITS-1:0] next_wdata;
   mem_req_s mem_req;

   ////////////////////////////////////////////////////////////////////////////////
   // Decode

   wire word_done = bit_cnt == `WORD_DONE_CNT; // R05
   wire ack_seen = bit_cnt == `ACK_IN_CNT;
   wire [`BIT_CNT_W-1:0] cnt_inc = bit_cnt + 1'b1;
   wire [`WORD_BITS-1:0] shift_in = {shreg[`WORD_BITS-2:0], link_bit};
   wire [`WORD_BITS-1:0] shift_out = {shreg[`WORD_BITS-2:0], 1'b0};
   wire type_ok = shreg[7:4] == `DEV_TYPE; // R08
   wire select_ok = shreg[3:1] == select_pins; // R09
   wire addr_match = type_ok & select_ok;
   wire [`PAGE_OFS_W-1:0] page_ofs_inc = addr[`PAGE_OFS_W-1:0] + 1'b1;
   wire [`ADDR_W-1:0] page_wrap_addr = {addr[`ADDR_W-1:`PAGE_OFS_W], page_ofs_inc}; // R14
   wire [`ADDR_W-1:0] linear_addr = addr + 1'b1; // R14
   wire [`ADDR_W-1:0] hi_loaded = {shreg[`ADDR_HI_W-1:0], addr[`WORD_BITS-1:0]};
   wire [`ADDR_W-1:0] lo_loaded = {addr[`ADDR_W-1:`WORD_BITS], shreg};
   wire wait_done = wait_cnt == TWR_W'(TWR_CYCLES - 1);
   wire [TWR_W-1:0] wait_inc = wait_cnt + 1'b1;
   wire [1:0] idx_inc = (byte_idx == `IDX_DATA) ? byte_idx : byte_idx + 1'b1;

   ////////////////////////////////////////////////////////////////////////////////
   // Next-state logic

   always_comb begin
      next_state = state;
      next_bit_cnt = bit_cnt;
      next_shreg = shreg;
      next_byte_idx = byte_idx;
      next_rw = rw;
      next_addr = addr;
      next_pending = pending;
      next_wait_cnt = wait_cnt;
      next_oe_n = oe_n;
      next_wr = 1'b0;
      next_wdata = mem_req.wdata;
      if (state == ST_WRITE_CYCLE) begin
         // Inputs are ignored and nothing is acknowledged until done
         next_oe_n = 1'b1; // R17
         if (wait_done) begin
            next_state = ST_STANDBY; // R04
            next_pending = 1'b0;
         end else begin
            next_wait_cnt = wait_inc; // R17
         end
      end else if (start_evt) begin
         next_state = ST_DEV_ADDR; // R02
         next_bit_cnt = '0; // R18
         next_byte_idx = `IDX_ADDR_HI;
         next_oe_n = 1'b1; // R18
      end else if (stop_evt) begin
         next_bit_cnt = '0; // R18
         next_oe_n = 1'b1; // R18
         next_wait_cnt = '0;
         next_state = pending ? ST_WRITE_CYCLE : ST_STANDBY; // R03 R04 R17
      end else begin
         case (state)
            ST_DEV_ADDR: begin
               if (rise_evt && !word_done) begin
                  next_shreg = shift_in;
                  next_bit_cnt = cnt_inc;
               end else if (fall_evt && word_done) begin
                  if (addr_match) begin
                     next_oe_n = 1'b0; // R12 R05
                     next_rw = shreg[0]; // R11
                     next_state = ST_ACK_OUT;
                  end else begin
                     next_oe_n = 1'b1; // R19
                     next_state = ST_IGNORE; // R12
                  end
               end
            end
            ST_RX_BYTE: begin
               if (rise_evt && !word_done) begin
                  next_shreg = shift_in;
                  next_bit_cnt = cnt_inc;
               end else if (fall_evt && word_done) begin
                  next_oe_n = 1'b0; // R05 R16
                  next_state = ST_ACK_OUT;
                  next_byte_idx = idx_inc;
                  case (byte_idx)
                     `IDX_ADDR_HI: next_addr = hi_loaded; // R16
                     `IDX_ADDR_LO: next_addr = lo_loaded; // R16
                     default: begin
                        // Protected bytes are acknowledged but never stored
                        if (!write_block) begin
                           next_wr = 1'b1; // R13
                           next_wdata = shreg;
                           next_pending = 1'b1;
                        end
                        next_addr = page_wrap_addr;
                     end
                  endcase
               end
            end
            ST_ACK_OUT: begin
               if (fall_evt) begin
                  next_bit_cnt = '0;
                  if (rw) begin
                     next_shreg = MEM_RDATA;
                     next_oe_n = MEM_RDATA[`WORD_BITS-1]; // R06 R07
                     next_state = ST_TX_BYTE;
                  end else begin
                     next_oe_n = 1'b1;
                     next_state = ST_RX_BYTE;
                  end
               end
            end
            ST_TX_BYTE: begin
               if (rise_evt && !word_done) begin
                  next_bit_cnt = cnt_inc;
               end else if (fall_evt && bit_cnt != '0) begin
                  if (word_done) begin
                     next_oe_n = 1'b1;
                     next_addr = linear_addr;
                     next_state = ST_ACK_IN;
                  end else begin
                     next_shreg = shift_out;
                     next_oe_n = shreg[`WORD_BITS-2]; // R06 R07
                  end
               end
            end
            ST_ACK_IN: begin
               if (rise_evt && word_done) begin
                  next_shreg = shift_in;
                  next_bit_cnt = cnt_inc;
               end else if (fall_evt && ack_seen) begin
                  next_bit_cnt = '0;
                  if (!shreg[0]) begin
                     next_shreg = MEM_RDATA;
                     next_oe_n = MEM_RDATA[`WORD_BITS-1];
                     next_state = ST_TX_BYTE;
                  end else begin
                     next_state = ST_IGNORE; // R19
                  end
               end
            end
            ST_IGNORE: next_oe_n = 1'b1; // R19
            ST_STANDBY: next_oe_n = 1'b1;
            default: begin
               next_state = ST_STANDBY;
               next_oe_n = 1'b1;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Registers

   wire next_standby = (next_state == ST_STANDBY) | (next_state == ST_IGNORE);
   wire next_busy = next_state == ST_WRITE_CYCLE;
   // Array address holds the written byte's place for the strobe cycle
   wire [`ADDR_W-1:0] next_mem_addr = next_wr ? addr : next_addr;

   always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
         state <= ST_STANDBY; // R04
         bit_cnt <= '0;
         shreg <= '0;
         byte_idx <= `IDX_ADDR_HI;
         rw <= 1'b0;
         addr <= '0;
         pending <= 1'b0;
         wait_cnt <= '0;
      end else begin
         state <= next_state;
         bit_cnt <= next_bit_cnt;
         shreg <= next_shreg;
         byte_idx <= next_byte_idx;
         rw <= next_rw;
         addr <= next_addr;
         pending <= next_pending;
         wait_cnt <= next_wait_cnt;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
         oe_n <= 1'b1;
         mem_req <= '0;
         STANDBY <= 1'b1;
         WRITE_BUSY <= 1'b0;
         SDA_OUT <= 1'b0;
      end else begin
         oe_n <= next_oe_n;
         mem_req <= '{wr: next_wr, addr: next_mem_addr, wdata: next_wdata};
         STANDBY <= next_standby;
         WRITE_BUSY <= next_busy;
         SDA_OUT <= 1'b0; // R07
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign SDA_OE_N = oe_n;
   assign MEM_REQ = mem_req;
   assign READ_MODE = rw;

endmodule : serial_eeprom_bus_front_end

// File: bench/eeprom_bus_monitor.sv
`timescale 1ns/1ns

module eeprom_bus_monitor
   import eeprom_pkg::*;
#(
   parameter int TWR_CYCLES = 50
) (
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic SRST,
   // Bus side
   input wire logic SCL,
   input wire logic SDA_OUT,
   input wire logic SDA_OE_N,
   // Protection, array and status
   input wire logic WRITE_PROTECT,
   input wire mem_req_s MEM_REQ,
   input wire logic STANDBY,
   input wire logic WRITE_BUSY
);
   int busy_cnt;

   always_ff @(posedge CORE_CLK) begin
      if (SRST || !WRITE_BUSY)
         busy_cnt <= 0;
      else
         busy_cnt <= busy_cnt + 1;
   end

   ////////////////////////////////////////
   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (SRST);

   sequence ack_pull;
      ##[0:2] !SDA_OE_N;
   endsequence
   sequence standby_soon;
      ##[0:2] STANDBY;
   endsequence

   open_drain_a: assert property (SDA_OUT == 1'b0)
      else $error("data output not low");
   pull_low_a: assert property ($fell(SDA_OE_N) |-> !SCL)
      else $error("line pulled while clock high");
   standby_quiet_a: assert property (STANDBY |-> SDA_OE_N)
      else $error("line pulled in standby");
   busy_quiet_a: assert property (WRITE_BUSY |-> SDA_OE_N && !STANDBY)
      else $error("activity during write cycle");
   busy_max_a: assert property (busy_cnt <= TWR_CYCLES + 1)
      else $error("write cycle too long");
   busy_min_a: assert property ($fell(WRITE_BUSY) |-> busy_cnt >= TWR_CYCLES - 2)
      else $error("write cycle too short");
   wake_standby_a: assert property ($fell(WRITE_BUSY) |-> standby_soon)
      else $error("no standby after write cycle");
   protect_block_a: assert property (WRITE_PROTECT && $past(WRITE_PROTECT, 4)
      |-> !MEM_REQ.wr)
      else $error("write while protected");
   wr_pulse_a: assert property (MEM_REQ.wr |=> !MEM_REQ.wr)
      else $error("write strobe too long");
   wr_ack_a: assert property (MEM_REQ.wr |-> ack_pull)
      else $error("stored byte not acknowledged");
endmodule : eeprom_bus_monitor

bind serial_eeprom_bus_front_end eeprom_bus_monitor #(.TWR_CYCLES(TWR_CYCLES)) i_eeprom_bus_monitor (
   .CORE_CLK(CORE_CLK), .SRST(SRST), .SCL(SCL), .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N),
   .WRITE_PROTECT(WRITE_PROTECT), .MEM_REQ(MEM_REQ), .STANDBY(STANDBY),
   .WRITE_BUSY(WRITE_BUSY));

// File: bench/eeprom_master.sv
`timescale 1ns/1ns

module eeprom_master (
   // Bus lines
   output logic scl,
   output logic sda_drv,
   input wire logic sda_line
);
   localparam int HALF = 300;

   // Clock idles high and stands still between frames
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end

   ////////////////////////////////////////
   task automatic start_c();
      #50 sda_drv = 1'b1;
      #HALF scl = 1'b1;
      #HALF sda_drv = 1'b0;
      #HALF scl = 1'b0;
   endtask : start_c

   task automatic stop_c();
      #50 sda_drv = 1'b0;
      #HALF scl = 1'b1;
      #HALF sda_drv = 1'b1;
      #HALF;
   endtask : stop_c

   task automatic recover();
      repeat (9) begin
         #HALF scl = 1'b0;
         #HALF scl = 1'b1;
      end
   endtask : recover

   // Data changes 50 ns into the low phase, never near an edge
   task automatic xfer(input logic [7:0] d, input int n, input logic ack,
                       output logic [7:0] q, output logic a);
      q = 8'h00;
      a = 1'b1;
      for (int i = 7; i > 7 - n; i--) begin
         #50 sda_drv = d[i];
         #HALF scl = 1'b1;
         q[i] = sda_line;
         #HALF scl = 1'b0;
      end
      if (n == 8) begin
         #50 sda_drv = ack;
         #HALF scl = 1'b1;
         a = sda_line;
         #HALF scl = 1'b0;
      end
      #50 sda_drv = 1'b1;
   endtask : xfer
endmodule : eeprom_master

// File: bench/serial_eeprom_bus_front_end_bench.sv
`timescale 1ns/1ns

module serial_eeprom_bus_front_end_bench
   import eeprom_pkg::*;
;
   localparam int TWR = 2000;
   logic core_clk, srst, scl, sda_drv, sda_line, sda_out, sda_oe_n, wp, a;
   logic standby, busy, read_mode;
   logic [2:0] sel;
   logic [7:0] rdata, q, wr_data;
   logic [13:0] wr_addr;
   mem_req_s mem_req;
   int miscompares, samples_checked, wr_cnt;

   // Wired-AND with pull-up
   assign sda_line = sda_drv & (sda_oe_n | sda_out);
   assign rdata = mem_req.addr[7:0] ^ {2'b01, mem_req.addr[13:8]};

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   always @(posedge core_clk) begin
      if (mem_req.wr === 1'b1) begin
         wr_cnt <= wr_cnt + 1;
         wr_addr <= mem_req.addr;
         wr_data <= mem_req.wdata;
      end
   end

   serial_eeprom_bus_front_end #(.TWR_CYCLES(TWR)) i_serial_eeprom_bus_front_end (
      .CORE_CLK(core_clk), .SRST(srst), .SCL(scl), .SDA_IN(sda_line), .SDA_OUT(sda_out),
      .SDA_OE_N(sda_oe_n), .SELECT_PIN_HIGH(sel[2]), .SELECT_PIN_MID(sel[1]),
      .SELECT_PIN_LOW(sel[0]), .WRITE_PROTECT(wp), .MEM_REQ(mem_req), .MEM_RDATA(rdata),
      .STANDBY(standby), .WRITE_BUSY(busy), .READ_MODE(read_mode));

   eeprom_master i_eeprom_master (.scl(scl), .sda_drv(sda_drv), .sda_line(sda_line));

   ////////////////////////////////////////
   task check(input string name, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   task stop_test();
      if (miscompares == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : stop_test

   task cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : cyc

   task put(input logic [7:0] d, input logic ack);
      i_eeprom_master.xfer(d, 8, 1'b1, q, a);
      check("ack", {15'h0, ack}, {15'h0, a});
   endtask : put

   task t_write();
      i_eeprom_master.start_c();
      put(8'haa, 1'b0);
      put(8'hc5, 1'b0);
      put(8'h3f, 1'b0);
      put(8'ha7, 1'b0);
      check("address", 16'h053f, {2'b00, wr_addr});
      check("data", 16'h00a7, {8'h00, wr_data});
      put(8'h5e, 1'b0);
      check("rollover", 16'h0500, {2'b00, wr_addr});
      i_eeprom_master.stop_c();
      cyc(10);
      check("busy", 16'h0002, {14'h0, busy, standby});
      i_eeprom_master.start_c();
      put(8'haa, 1'b1);
      i_eeprom_master.stop_c();
      for (int i = 0; i < TWR + 200 && busy !== 1'b0; i++) cyc(1);
      check("standby", 16'h0001, {15'h0, standby});
   endtask : t_write

   task t_protect();
      int n;
      n = wr_cnt;
      wp = 1'b1;
      cyc(4);
      i_eeprom_master.start_c();
      put(8'haa, 1'b0);
      put(8'h00, 1'b0);
      put(8'h10, 1'b0);
      put(8'h55, 1'b0);
      i_eeprom_master.stop_c();
      cyc(20);
      check("writes", n[15:0], wr_cnt[15:0]);
      check("busy", 16'h0000, {15'h0, busy});
      wp = 1'b0;
   endtask : t_protect

   task t_read();
      i_eeprom_master.start_c();
      put(8'haa, 1'b0);
      put(8'hff, 1'b0);
      put(8'hff, 1'b0);
      i_eeprom_master.start_c();
      put(8'hab, 1'b0);
      check("mode", 16'h0001, {15'h0, read_mode});
      i_eeprom_master.xfer(8'hff, 8, 1'b0, q, a);
      check("read", 16'h0080, {8'h00, q});
      i_eeprom_master.xfer(8'hff, 8, 1'b1, q, a);
      check("wrap", 16'h0040, {8'h00, q});
      i_eeprom_master.stop_c();
      cyc(10);
      check("standby", 16'h0001, {15'h0, standby});
   endtask : t_read

   task t_refuse();
      i_eeprom_master.start_c();
      put(8'hac, 1'b1);
      cyc(10);
      check("standby", 16'h0001, {15'h0, standby});
      i_eeprom_master.start_c();
      put(8'hba, 1'b1);
      i_eeprom_master.stop_c();
      sel = 3'b000;
      cyc(4);
      i_eeprom_master.start_c();
      put(8'ha0, 1'b0);
      i_eeprom_master.stop_c();
      sel = 3'b101;
      cyc(4);
      i_eeprom_master.start_c();
      i_eeprom_master.xfer(8'hff, 3, 1'b1, q, a);
      i_eeprom_master.stop_c();
      i_eeprom_master.start_c();
      put(8'haa, 1'b0);
      i_eeprom_master.stop_c();
   endtask : t_refuse

   // Long write cycle is shortened through TWR, so 0.5 ms is ample
   initial begin
      #500000;
      miscompares++;
      stop_test();
   end

   initial begin
      srst = 1'b0;
      wp = 1'b0;
      sel = 3'b101;
      cyc(1);
      srst = 1'b1;
      cyc(8);
      srst = 1'b0;
      cyc(4);
      i_eeprom_master.recover();
      t_write();
      t_protect();
      t_read();
      t_refuse();
      stop_test();
   end
endmodule : serial_eeprom_bus_front_end_bench
